// *** pkg/dlb_pkg.sv ***
// Purpose: constants and types of the dac output limiter and boost stage
// Assumes: sample strobes arrive at the audio sample rate
// Notes:   gain is kept in half-dB steps with a binary fraction below
package dlb_pkg;

  // register map and fields
  localparam int unsigned           ADDR_W       = 7;
  localparam int unsigned           REG_W        = 9;
  localparam logic [ADDR_W-1:0]     ADDR_TIMING  = 7'h18;
  localparam logic [ADDR_W-1:0]     ADDR_LEVEL   = 7'h19;
  localparam logic [ADDR_W-1:0]     ADDR_STATUS  = 7'h1A;
  localparam logic [REG_W-1:0]      TIMING_RST   = 9'h032;
  localparam logic [REG_W-1:0]      LEVEL_RST    = 9'h000;
  localparam int unsigned           ON_BIT       = 8;
  localparam int unsigned           RCV_HI       = 7;
  localparam int unsigned           RCV_LO       = 4;
  localparam int unsigned           RED_HI       = 3;
  localparam int unsigned           RED_LO       = 0;
  localparam int unsigned           LVL_HI       = 6;
  localparam int unsigned           LVL_LO       = 4;
  localparam int unsigned           BST_HI       = 3;
  localparam int unsigned           BST_LO       = 0;
  localparam logic [3:0]            BOOST_MAX    = 4'hC;
  localparam logic [3:0]            TIME_MAX     = 4'hB;
  localparam logic [2:0]            LVL_MAX      = 3'h5;

  // rate timing, defined at the reference sample rate
  localparam longint unsigned       REF_RATE_HZ  = 44100;
  localparam longint unsigned       NS_PER_S     = 1_000_000_000;
  localparam longint unsigned       RED_BASE_NS  = 94_000;
  localparam longint unsigned       RCV_BASE_NS  = 750_000;
  localparam int unsigned           STEPS_6DB    = 12;
  localparam int unsigned           FRAC_W       = 16;
  localparam int unsigned           INC_W        = 18;
  localparam logic [INC_W-1:0]      RED_INC0     = INC_W'((longint'(STEPS_6DB) << FRAC_W) * NS_PER_S
                                                   / (RED_BASE_NS * REF_RATE_HZ));
  localparam logic [INC_W-1:0]      RCV_INC0     = INC_W'((longint'(STEPS_6DB) << FRAC_W) * NS_PER_S
                                                   / (RCV_BASE_NS * REF_RATE_HZ));

  // gain word: signed half-dB integer part, FRAC_W fraction bits
  localparam int unsigned           HD_W         = 7;
  localparam int unsigned           GAIN_W       = HD_W + FRAC_W;
  localparam int                    GAIN_FLOOR   = -24;
  localparam int unsigned           EXP_BIAS     = 2;
  localparam int unsigned           MANT_FRAC    = 15;
  localparam int unsigned           THR_FRAC     = 16;

  // 2^(k/12) in q1.15, one entry per half-dB inside one 6 dB octave
  localparam logic [11:0][15:0]     MANT_TAB     = {
    16'hF1A2, 16'hE412, 16'hD745, 16'hCB30, 16'hBFC9, 16'hB505,
    16'hAADC, 16'hA145, 16'h9838, 16'h8FAD, 16'h879C, 16'h8000};
  // full-scale fractions at -0.5 dB .. -6.5 dB in 1 dB steps
  localparam logic [6:0][15:0]      THR_TAB      = {
    16'h7920, 16'h87E8, 16'h987D, 16'hAB18, 16'hBFF9, 16'hD766, 16'hF1AE};

  // stream and register carriers
  localparam int unsigned           SAMPLE_W     = 24;

  typedef struct packed {
    logic                      valid;
    logic signed [SAMPLE_W-1:0] data;
  } dlb_sample_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [REG_W-1:0]  wdata;
  } dlb_regreq_t;

  typedef enum logic [1:0] {
    DLB_HOLD   = 2'b00,
    DLB_ATTACK = 2'b01,
    DLB_DECAY  = 2'b10
  } dlb_phase_t;

endpackage : dlb_pkg

// *** rtl/dlb_limiter_boost.sv ***
// Purpose: digital peak limiter and volume boost on the dac sample stream
// Assumes: one sample strobe per audio sample, synchronous to clk_sys
// Notes:   gain moves only on sample strobes, so all times track the rate
//
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module dlb_limiter_boost (
  input  wire logic                 clk_sys,
  input  wire logic                 reset,
  input  wire dlb_pkg::dlb_regreq_t regReq,
  output logic [dlb_pkg::REG_W-1:0] regRdata,
  input  wire dlb_pkg::dlb_sample_t sampleIn,
  output dlb_pkg::dlb_sample_t      sampleOut
);

  localparam int unsigned PROD_W = dlb_pkg::SAMPLE_W + 17;
  localparam int unsigned WIDE_W = PROD_W + 4;

  localparam logic signed [WIDE_W-1:0] SAT_MAX =
    WIDE_W'((longint'(1) << (dlb_pkg::SAMPLE_W - 1)) - 1);
  localparam logic signed [WIDE_W-1:0] SAT_MIN = -SAT_MAX - WIDE_W'(1);

  localparam logic signed [dlb_pkg::GAIN_W:0] FLOOR_FX =
    (dlb_pkg::GAIN_W + 1)'(dlb_pkg::GAIN_FLOOR) <<< dlb_pkg::FRAC_W;

  // ---------------- register file ----------------

  logic [dlb_pkg::REG_W-1:0] timing_q;
  logic [dlb_pkg::REG_W-1:0] timing_d;
  logic [dlb_pkg::REG_W-1:0] level_q;
  logic [dlb_pkg::REG_W-1:0] level_d;
  logic [dlb_pkg::REG_W-1:0] rdata_q;
  logic [dlb_pkg::REG_W-1:0] rdata_d;
  logic [dlb_pkg::REG_W-1:0] status;

  always_comb begin
    timing_d = timing_q;
    level_d  = level_q;
    rdata_d  = '0;
    if (regReq.wr) begin
      case (regReq.addr)
        dlb_pkg::ADDR_TIMING: timing_d = regReq.wdata;
        dlb_pkg::ADDR_LEVEL:  level_d  = regReq.wdata;
        default: ;
      endcase
    end
    // unmapped reads return zero; read data lasts one cycle only
    if (regReq.rd) begin
      case (regReq.addr)
        dlb_pkg::ADDR_TIMING: rdata_d = timing_q;
        dlb_pkg::ADDR_LEVEL:  rdata_d = level_q;
        dlb_pkg::ADDR_STATUS: rdata_d = status;
        default:              rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      timing_q <= dlb_pkg::TIMING_RST;
      level_q  <= dlb_pkg::LEVEL_RST;
      rdata_q  <= '0;
    end else begin
      timing_q <= timing_d;
      level_q  <= level_d;
      rdata_q  <= rdata_d;
    end
  end

  assign regRdata = rdata_q;

  // ---------------- field decode ----------------

  logic       limiterOn;
  logic [3:0] gainRecoveryTime;
  logic [3:0] gainReductionTime;
  logic [2:0] thresholdLevel;
  logic [3:0] boostGain;
  logic [3:0] boostCode;
  logic [3:0] rcvShift;
  logic [3:0] redShift;
  logic [2:0] lvlIdx;

  assign limiterOn         = timing_q[dlb_pkg::ON_BIT];
  assign gainRecoveryTime  = timing_q[dlb_pkg::RCV_HI:dlb_pkg::RCV_LO];
  assign gainReductionTime = timing_q[dlb_pkg::RED_HI:dlb_pkg::RED_LO];
  assign thresholdLevel    = level_q[dlb_pkg::LVL_HI:dlb_pkg::LVL_LO];
  assign boostGain         = level_q[dlb_pkg::BST_HI:dlb_pkg::BST_LO];

  // reserved boost codes are clamped so the gain never leaves its range
  assign boostCode = (boostGain > dlb_pkg::BOOST_MAX) ? dlb_pkg::BOOST_MAX : boostGain;

  // each code doubles the time per 6 dB, so the step halves
  assign rcvShift = (gainRecoveryTime > dlb_pkg::TIME_MAX) ?
                    dlb_pkg::TIME_MAX : gainRecoveryTime;
  assign redShift = (gainReductionTime > dlb_pkg::TIME_MAX) ?
                    dlb_pkg::TIME_MAX : gainReductionTime;
  assign lvlIdx   = (thresholdLevel > dlb_pkg::LVL_MAX) ?
                    dlb_pkg::LVL_MAX : thresholdLevel;

  // ---------------- gain to linear ----------------

  logic signed [dlb_pkg::GAIN_W-1:0] gain_q;
  logic signed [dlb_pkg::GAIN_W-1:0] gain_d;
  logic signed [dlb_pkg::HD_W-1:0]   halfDb;
  logic [5:0]                        hdPos;
  logic [2:0]                        expPos;
  logic [3:0]                        mantIdx;
  logic [15:0]                       mant;

  assign halfDb  = gain_q[dlb_pkg::GAIN_W-1:dlb_pkg::FRAC_W];
  assign hdPos   = 6'(halfDb - dlb_pkg::HD_W'(dlb_pkg::GAIN_FLOOR));
  assign expPos  = 3'(hdPos / 6'(dlb_pkg::STEPS_6DB));
  assign mantIdx = 4'(hdPos % 6'(dlb_pkg::STEPS_6DB));
  assign mant    = dlb_pkg::MANT_TAB[mantIdx];

  // ---------------- gain stage ----------------

  logic signed [PROD_W-1:0] prod;
  logic signed [WIDE_W-1:0] wide;
  logic signed [WIDE_W-1:0] scaled;
  logic signed [WIDE_W-1:0] satVal;
  logic [WIDE_W-1:0]        mag;

  // trade-off: one full multiply per sample keeps the gain exact to the table
  assign prod   = sampleIn.data * $signed({1'b0, mant});
  assign wide   = WIDE_W'(prod) <<< expPos;
  assign scaled = wide >>> (dlb_pkg::MANT_FRAC + dlb_pkg::EXP_BIAS);

  always_comb begin
    if (scaled > SAT_MAX) begin
      satVal = SAT_MAX;
    end else if (scaled < SAT_MIN) begin
      satVal = SAT_MIN;
    end else begin
      satVal = scaled;
    end
  end

  // level is judged on the unclipped result, so clipping cannot hide a peak
  assign mag = scaled[WIDE_W-1] ? WIDE_W'(-scaled) : WIDE_W'(scaled);

  // ---------------- thresholds ----------------

  logic [WIDE_W-1:0] thrUpper;
  logic [WIDE_W-1:0] thrLower;

  assign thrUpper = WIDE_W'((SAT_MAX * $signed({1'b0, dlb_pkg::THR_TAB[lvlIdx]}))
                    >>> dlb_pkg::THR_FRAC);
  assign thrLower = WIDE_W'((SAT_MAX * $signed({1'b0, dlb_pkg::THR_TAB[lvlIdx + 3'h1]}))
                    >>> dlb_pkg::THR_FRAC);

  // ---------------- gain control ----------------

  dlb_pkg::dlb_phase_t               phase_q;
  dlb_pkg::dlb_phase_t               phase_d;
  logic signed [dlb_pkg::GAIN_W:0]   target;
  logic signed [dlb_pkg::GAIN_W:0]   cur;
  logic signed [dlb_pkg::GAIN_W:0]   down;
  logic signed [dlb_pkg::GAIN_W:0]   up;
  logic [dlb_pkg::INC_W-1:0]         atkInc;
  logic [dlb_pkg::INC_W-1:0]         dcyInc;

  // target gain is the boost, two half-dB units per code
  assign target = (dlb_pkg::GAIN_W + 1)'({boostCode, 1'b0}) <<< dlb_pkg::FRAC_W;
  assign cur    = (dlb_pkg::GAIN_W + 1)'(gain_q);
  assign atkInc = dlb_pkg::RED_INC0 >> redShift;
  assign dcyInc = dlb_pkg::RCV_INC0 >> rcvShift;
  assign down   = cur - (dlb_pkg::GAIN_W + 1)'(atkInc);
  assign up     = cur + (dlb_pkg::GAIN_W + 1)'(dcyInc);

  always_comb begin
    gain_d  = gain_q;
    phase_d = phase_q;
    if (sampleIn.valid) begin
      if (!limiterOn) begin
        gain_d  = dlb_pkg::GAIN_W'(target);
        phase_d = dlb_pkg::DLB_HOLD;
      end else if (mag > thrUpper) begin
        phase_d = dlb_pkg::DLB_ATTACK;
        gain_d  = (down < FLOOR_FX) ? dlb_pkg::GAIN_W'(FLOOR_FX) : dlb_pkg::GAIN_W'(down);
      end else if ((mag < thrLower) && (cur < target)) begin
        phase_d = dlb_pkg::DLB_DECAY;
        gain_d  = (up > target) ? dlb_pkg::GAIN_W'(target) : dlb_pkg::GAIN_W'(up);
      end else begin
        phase_d = dlb_pkg::DLB_HOLD;
        // a lowered boost pulls the gain straight down to the new ceiling
        if (cur > target) begin
          gain_d = dlb_pkg::GAIN_W'(target);
        end
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      gain_q  <= '0;
      phase_q <= dlb_pkg::DLB_HOLD;
    end else begin
      gain_q  <= gain_d;
      phase_q <= phase_d;
    end
  end

  // status: phase in the top bits, signed half-dB gain below
  assign status = {phase_q, halfDb};

  // ---------------- output ----------------

  dlb_pkg::dlb_sample_t out_q;
  dlb_pkg::dlb_sample_t out_d;

  always_comb begin
    out_d       = out_q;
    out_d.valid = sampleIn.valid;
    if (sampleIn.valid) begin
      out_d.data = dlb_pkg::SAMPLE_W'(satVal);
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      out_q <= '0;
    end else begin
      out_q <= out_d;
    end
  end

  assign sampleOut = out_q;

endmodule : dlb_limiter_boost

`default_nettype wire

// *** tb/dlb_limiter_boost_assertions.sv ***
// Purpose: port-level checks of the limiter and boost stage
// Assumes: one clock domain; register writes shadowed here
// Notes:   gain bound inferred from config seen at each strobe
`timescale 1ns/10ps
`default_nettype none
module dlb_limiter_boost_assertions (
  input wire logic                      clk_sys,
  input wire logic                      reset,
  input wire dlb_pkg::dlb_regreq_t      regReq,
  input wire logic [dlb_pkg::REG_W-1:0] regRdata,
  input wire dlb_pkg::dlb_sample_t      sampleIn,
  input wire dlb_pkg::dlb_sample_t      sampleOut
);
  logic [8:0] tim_q, tim_d, lvl_q, lvl_d;
  logic       unity_q, unity_d, cap_q, cap_d;
  function automatic logic [23:0] mag(input logic signed [23:0] v);
    return v[23] ? 24'(-v) : 24'(v);
  endfunction : mag
  // gain takes the target only at a strobe, so flags move on strobes too
  always_comb begin
    tim_d = tim_q;
    lvl_d = lvl_q;
    unity_d = unity_q;
    cap_d = cap_q;
    if (regReq.wr && regReq.addr == dlb_pkg::ADDR_TIMING) tim_d = regReq.wdata;
    if (regReq.wr && regReq.addr == dlb_pkg::ADDR_LEVEL) lvl_d = regReq.wdata;
    if (sampleIn.valid) begin
      unity_d = !tim_q[dlb_pkg::ON_BIT] && lvl_q[3:0] == 4'h0;
      cap_d = lvl_q[3:0] == 4'h0;
    end
  end
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tim_q <= dlb_pkg::TIMING_RST;
      lvl_q <= dlb_pkg::LEVEL_RST;
      unity_q <= 1'b1;
      cap_q <= 1'b1;
    end else begin
      tim_q <= tim_d;
      lvl_q <= lvl_d;
      unity_q <= unity_d;
      cap_q <= cap_d;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_out_valid_follows: assert property (sampleIn.valid |=> sampleOut.valid)
    else $error("output strobe missing");
  a_no_spurious_valid: assert property (!sampleIn.valid |=> !sampleOut.valid)
    else $error("output strobe without input");
  a_data_held: assert property (!sampleIn.valid |=> $stable(sampleOut.data))
    else $error("output word moved between strobes");
  a_rdata_idle_zero: assert property (!regReq.rd |=> regRdata == 9'h000)
    else $error("read data not zero outside read");
  a_timing_readback: assert property ((regReq.wr && regReq.addr == dlb_pkg::ADDR_TIMING) ##1
    (regReq.rd && regReq.addr == dlb_pkg::ADDR_TIMING) |=> regRdata == $past(regReq.wdata, 2))
    else $error("timing register readback wrong");
  a_level_readback: assert property ((regReq.wr && regReq.addr == dlb_pkg::ADDR_LEVEL) ##1
    (regReq.rd && regReq.addr == dlb_pkg::ADDR_LEVEL) |=> regRdata == $past(regReq.wdata, 2))
    else $error("level register readback wrong");
  a_unmapped_zero: assert property (regReq.rd && regReq.addr < dlb_pkg::ADDR_TIMING |=> regRdata == 9'h000)
    else $error("unmapped read not zero");
  a_unity_pass: assert property (sampleIn.valid && unity_q |=> sampleOut.data == $past(sampleIn.data))
    else $error("zero boost bypass altered sample");
  a_no_gain_boost0: assert property (sampleIn.valid && cap_q |=>
    mag(sampleOut.data) <= mag($past(sampleIn.data)))
    else $error("gain above unity with zero boost");
  c_limiting: cover property (sampleIn.valid && tim_q[dlb_pkg::ON_BIT]);
  c_full_boost: cover property (sampleIn.valid && lvl_q[3:0] == 4'hC);
  c_readback: cover property (regReq.wr ##1 regReq.rd);
endmodule : dlb_limiter_boost_assertions
`default_nettype wire

// *** tb/dlb_limiter_boost_tb.sv ***
// Purpose: self-checking bench for the limiter and boost stage
// Assumes: gain figures allow 1 percent table rounding
// Notes:   reserved boost codes are never written
`timescale 1ns/10ps
`default_nettype none
module dlb_limiter_boost_tb;
  localparam logic signed [23:0] AMP = 24'h10_0000;
  localparam logic signed [23:0] FS  = 24'h7F_FFFF;
  logic                 clk_sys;
  logic                 reset;
  logic [3:0]           gap;
  logic [8:0]           regRdata;
  logic signed [23:0]   y;
  dlb_pkg::dlb_regreq_t regReq;
  dlb_pkg::dlb_sample_t sampleIn;
  dlb_pkg::dlb_sample_t sampleOut;
  int                   n_errors, checks, cycles, n, n0, n3;
  dlb_limiter_boost uut (.clk_sys(clk_sys), .reset(reset), .regReq(regReq), .regRdata(regRdata),
    .sampleIn(sampleIn), .sampleOut(sampleOut));
  dlb_sample_source src (.clk_sys(clk_sys), .gap(gap), .sampleIn(sampleIn));
  task automatic chk_reg(input logic [8:0] got, input logic [8:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_smp(input logic signed [23:0] got, input real exp);
    real d;
    d = real'(got) - exp;
    checks++;
    if ($isunknown(got) || (d < 0.0 ? -d : d) > 0.01 * (exp < 0.0 ? -exp : exp) + 2.0) begin
      n_errors++;
      $display("ERROR %0t sample %0d expected %0f", $time, got, exp);
    end
  endtask : chk_smp
  task automatic rd_chk(input logic [6:0] a, input logic [8:0] exp);
    @(posedge clk_sys);
    regReq.rd <= 1'b1;
    regReq.addr <= a;
    @(posedge clk_sys);
    regReq.rd <= 1'b0;
    #1 chk_reg(regRdata, exp);
  endtask : rd_chk
  task automatic wr_chk(input logic [6:0] a, input logic [8:0] v, input logic [8:0] exp);
    @(posedge clk_sys);
    regReq.wr <= 1'b1;
    regReq.addr <= a;
    regReq.wdata <= v;
    @(posedge clk_sys);
    regReq.wr <= 1'b0;
    regReq.rd <= 1'b1;
    @(posedge clk_sys);
    regReq.rd <= 1'b0;
    #1 chk_reg(regRdata, exp);
  endtask : wr_chk
  task automatic smp(input logic signed [23:0] d, output logic signed [23:0] o);
    src.send(d);
    #1 chk_reg({8'h00, sampleOut.valid}, 9'h001);
    o = sampleOut.data;
  endtask : smp
  task automatic results;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 10000) begin
      n_errors++;
      $display("ERROR %0t run did not finish", $time);
      results();
    end
  end
  initial begin
    reset = 1'b1;
    regReq = '0;
    gap = 4'h0;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    rd_chk(dlb_pkg::ADDR_TIMING, dlb_pkg::TIMING_RST);
    rd_chk(dlb_pkg::ADDR_LEVEL, dlb_pkg::LEVEL_RST);
    wr_chk(7'h00, 9'h1FF, 9'h000);
    wr_chk(dlb_pkg::ADDR_TIMING, 9'h0A5, 9'h0A5);
    for (int c = 0; c <= 12; c++) begin
      wr_chk(dlb_pkg::ADDR_LEVEL, 9'(32 + c), 9'(32 + c));
      smp(AMP, y);
      smp(-AMP, y);
      chk_smp(y, -real'(AMP) * 10.0 ** (c / 20.0));
    end
    smp(24'sh60_0000, y);
    chk_smp(y, 8388607.0);
    smp(-24'sh60_0000, y);
    chk_smp(y, -8388608.0);
    // threshold -5.5 dB: the cut must run several half-dB steps before it ends
    for (int k = 0; k < 2; k++) begin
      wr_chk(dlb_pkg::ADDR_LEVEL, 9'h050, 9'h050);
      wr_chk(dlb_pkg::ADDR_TIMING, 9'h000, 9'h000);
      smp(AMP, y);
      wr_chk(dlb_pkg::ADDR_TIMING, 9'(256 + 3 * k), 9'(256 + 3 * k));
      n = 0;
      y = FS;
      while (n < 40 && real'(y) > real'(FS) * 10.0 ** (-5.5 / 20.0)) begin
        smp(FS, y);
        n++;
      end
      if (k == 0) n0 = n;
      else n3 = n;
    end
    chk_reg(9'(n0 == 5 && n3 > n0 && n3 < 40), 9'h001);
    gap = 4'h3;
    wr_chk(dlb_pkg::ADDR_LEVEL, 9'h006, 9'h006);
    repeat (6) smp(AMP, y);
    chk_reg(9'(real'(y) < real'(AMP) * 1.5), 9'h001);
    repeat (80) smp(AMP, y);
    chk_smp(y, real'(AMP) * 10.0 ** (6.0 / 20.0));
    rd_chk(dlb_pkg::ADDR_STATUS, 9'h00C);
    wr_chk(dlb_pkg::ADDR_LEVEL, 9'h000, 9'h000);
    repeat (4) smp(AMP, y);
    chk_smp(y, real'(AMP));
    results();
  end
endmodule : dlb_limiter_boost_tb
bind dlb_limiter_boost dlb_limiter_boost_assertions u_chk (.clk_sys(clk_sys), .reset(reset),
  .regReq(regReq), .regRdata(regRdata), .sampleIn(sampleIn), .sampleOut(sampleOut));
`default_nettype wire

// *** tb/dlb_sample_source.sv ***
// Purpose: audio interface model feeding dac sample words
// Assumes: caller waits for each send to return
// Notes:   gap stretches spacing; gain steps per strobe
`timescale 1ns/10ps
`default_nettype none
module dlb_sample_source (
  input  wire logic           clk_sys,
  input  wire logic [3:0]     gap,
  output var dlb_pkg::dlb_sample_t sampleIn
);
  initial sampleIn = '0;
  task automatic send(input logic signed [23:0] d);
    repeat (gap) @(posedge clk_sys);
    @(posedge clk_sys);
    sampleIn.valid <= 1'b1;
    sampleIn.data  <= d;
    @(posedge clk_sys);
    sampleIn.valid <= 1'b0;
    // stale word inverted so it never passes for the last sample
    sampleIn.data  <= ~d;
  endtask : send
endmodule : dlb_sample_source
`default_nettype wire
